// ---- logic/plbm_map.svh ----
//----------------------------------------------------------------------
// Purpose : Constants for the picture level bounce modifier
// Assumes : 50 MHz sample clock, 10-bit composite samples
// Notes   : Offsets, levels, codes and timing figures live here only
//----------------------------------------------------------------------
`ifndef PLBM_MAP_SVH
`define PLBM_MAP_SVH

// ************************************************************
// Mode select codes on the settings port
// ************************************************************
`define PLBM_CODE_PASS    3'h0
`define PLBM_CODE_BRIGHT  3'h1
`define PLBM_CODE_DARK    3'h2
`define PLBM_CODE_ALT     3'h3
`define PLBM_CODE_BOUNCE  3'h4

// ************************************************************
// Line grouping and flat field levels
// ************************************************************
`define PLBM_GROUP_NTSC   3'h5
`define PLBM_GROUP_PAL    3'h4
`define PLBM_LEVEL_FULL   10'h3c0
`define PLBM_LEVEL_ZERO   10'h040

// ************************************************************
// Timing: period code n means (n + 1) half-second steps
// ************************************************************
`define PLBM_CLK_HZ       50000000
`define PLBM_STEP_MS      500
`define PLBM_STEP_CYC     ((`PLBM_CLK_HZ / 1000) * `PLBM_STEP_MS)
`define PLBM_PERIOD_DFLT  2'h1

`endif

// ---- logic/plbm_pkg.sv ----
//----------------------------------------------------------------------
// Purpose : Types shared by the picture level bounce modifier
// Assumes : Nothing beyond the map header
// Notes   : Modes are one-hot
//----------------------------------------------------------------------
package plbm_pkg;

  // One-hot picture level modes
  typedef enum logic [4:0] {
    PASS_THROUGH_MODE       = 5'h01,
    BRIGHT_LEVEL_MODE       = 5'h02,
    DARK_LEVEL_MODE         = 5'h04,
    LEVEL_ALTERNATION_MODE  = 5'h08,
    BOUNCE_MODE             = 5'h10
  } plbm_mode_e;

  // One composite video sample
  typedef logic [9:0] plbm_sample_t;

endpackage : plbm_pkg

// ---- logic/plbm_period_timer.sv ----
//----------------------------------------------------------------------
// Purpose : Counts the alternation period in half-second steps
// Assumes : Step length given in clock cycles by the parent
// Notes   : Emits a one-cycle pulse at the end of each period
//----------------------------------------------------------------------
`timescale 1ns/1ns
`include "plbm_map.svh"

module plbm_period_timer
  import plbm_pkg::*;
#(
  parameter int unsigned STEP_CYC = `PLBM_STEP_CYC
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_run,       // Count only while high
  input  wire logic [1:0] i_steps_m1,  // Half-second steps minus one
  output logic            o_expired    // Period end pulse
);

  logic [24:0] cyc_reg;   // Cycles within the current step
  logic [1:0]  step_reg;  // Steps done within the period
  logic        step_end;  // Last cycle of a step

  assign step_end = (cyc_reg == 25'(STEP_CYC - 1));

  // ************************************************************
  // Step cycle counter
  // ************************************************************
  // Cleared while idle so each period starts whole
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cyc_reg <= 25'h0000000;
    end else if (!i_run || step_end) begin
      cyc_reg <= 25'h0000000;
    end else begin
      cyc_reg <= cyc_reg + 25'h0000001;
    end
  end

  // Step counter within the period
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      step_reg <= 2'h0;
    end else if (!i_run) begin
      step_reg <= 2'h0;
    end else if (step_end) begin
      // Wrap at the programmed step count
      step_reg <= (step_reg >= i_steps_m1) ? 2'h0 : step_reg + 2'h1;
    end
  end

  // Period end pulse, registered
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_expired <= 1'b0;
    end else begin
      o_expired <= i_run && step_end && (step_reg >= i_steps_m1);
    end
  end

endmodule : plbm_period_timer

// ---- logic/plbm_modifier.sv ----
//----------------------------------------------------------------------
// Purpose : Picture level modifier for the main test signal output
// Assumes : Stream inputs come from logic on i_ref_clk
// Notes   : Settings take effect at the next frame start
//----------------------------------------------------------------------
// What this block does
// - Level effects touch only the main output
// - Pass-through forwards the pattern unchanged
// - Bright: groups of 5/4, others full
// - Dark: groups of 5/4, others zero
// - Alternation swaps bright and dark per period
// - Bounce swaps full and zero field per period
// - Period 0.5 to 2 s, alternating modes
// - Default recall: pass-through, one second period
`timescale 1ns/1ns
`include "plbm_map.svh"

module plbm_modifier
  import plbm_pkg::*;
#(
  parameter int unsigned STEP_CYC = `PLBM_STEP_CYC  // Half-second cycles
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_sys_rst,
  input  wire plbm_sample_t i_main_data,      // Selected pattern sample
  input  wire logic         i_main_active,    // Active video sample
  input  wire logic         i_line_start,     // First sample of a line
  input  wire logic         i_frame_start,    // First sample of a frame
  input  wire plbm_sample_t i_aux_data,       // Other module output
  input  wire logic         i_fmt_pal,        // High for PAL
  input  wire logic [2:0]   i_mode_code,      // Requested mode code
  input  wire logic [1:0]   i_period_code,    // Half-second steps - 1
  input  wire logic         i_settings_load,  // Take mode and period
  input  wire logic         i_default_recall, // Factory default recall
  output plbm_sample_t      o_main_data,      // Modified main sample
  output plbm_sample_t      o_aux_data,       // Untouched other output
  output logic              o_dark_phase      // High in the dark half
);

  // ************************************************************
  // Declarations
  // ************************************************************
  plbm_mode_e   pend_mode_reg;    // Mode waiting for a frame start
  logic [1:0]   pend_period_reg;  // Period waiting for a frame start
  plbm_mode_e   mode_reg;         // Mode in force
  logic [1:0]   period_reg;       // Period in force
  logic [2:0]   line_cnt_reg;     // Line within the group
  logic         phase_reg;        // Low bright/full, high dark/zero
  logic         swap_pend_reg;    // Period ended, awaiting frame
  logic         expired;          // Timer period end
  logic         alternating;      // One of the two alternating modes
  logic [2:0]   group_len;        // Lines per group for the format
  logic         last_line;        // Last line of a group
  plbm_sample_t main_next;        // Next main output sample

  // Decode a mode code; unknown codes fall back to pass-through
  function automatic plbm_mode_e plbm_decode(input logic [2:0] code);
    case (code)
      `PLBM_CODE_BRIGHT: plbm_decode = BRIGHT_LEVEL_MODE;
      `PLBM_CODE_DARK:   plbm_decode = DARK_LEVEL_MODE;
      `PLBM_CODE_ALT:    plbm_decode = LEVEL_ALTERNATION_MODE;
      `PLBM_CODE_BOUNCE: plbm_decode = BOUNCE_MODE;
      default:           plbm_decode = PASS_THROUGH_MODE;
    endcase
  endfunction : plbm_decode

  // ************************************************************
  // Settings
  // ************************************************************
  // Default recall wins
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pend_mode_reg   <= PASS_THROUGH_MODE;
      pend_period_reg <= `PLBM_PERIOD_DFLT;
    end else if (i_default_recall) begin
      pend_mode_reg   <= plbm_decode(`PLBM_CODE_PASS);
      pend_period_reg <= `PLBM_PERIOD_DFLT;
    end else if (i_settings_load) begin
      pend_mode_reg   <= plbm_decode(i_mode_code);
      pend_period_reg <= i_period_code;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_reg   <= PASS_THROUGH_MODE;
      period_reg <= `PLBM_PERIOD_DFLT;
    end else if (i_frame_start) begin
      mode_reg   <= pend_mode_reg;
      period_reg <= pend_period_reg;
    end
  end

  // ************************************************************
  // Line grouping
  // ************************************************************
  assign group_len = i_fmt_pal ? `PLBM_GROUP_PAL : `PLBM_GROUP_NTSC;
  assign last_line = (line_cnt_reg == group_len - 3'h1);

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      line_cnt_reg <= 3'h0;
    end else if (i_frame_start) begin
      line_cnt_reg <= 3'h0;          // Groups restart each frame
    end else if (i_line_start) begin
      line_cnt_reg <= last_line ? 3'h0 : line_cnt_reg + 3'h1;
    end
  end

  // ************************************************************
  // Alternation period and phase
  // ************************************************************
  assign alternating = (mode_reg == LEVEL_ALTERNATION_MODE) ||
                       (mode_reg == BOUNCE_MODE);

  plbm_period_timer #(
    .STEP_CYC   (STEP_CYC)
  ) u_timer (
    .i_ref_clk  (i_ref_clk),
    .i_sys_rst  (i_sys_rst),
    .i_run      (alternating),
    .i_steps_m1 (period_reg),
    .o_expired  (expired)
  );

  // Pending swap; a new period end wins over the frame clear
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      swap_pend_reg <= 1'b0;
    end else if (expired) begin
      swap_pend_reg <= 1'b1;
    end else if (i_frame_start || !alternating) begin
      swap_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      phase_reg <= 1'b0;
    end else if (i_frame_start) begin
      if (!alternating) begin
        phase_reg <= 1'b0;           // Alternating modes start bright when entered from a non-alternating mode
      end else if (swap_pend_reg) begin
        phase_reg <= ~phase_reg;
      end
    end
  end

  assign o_dark_phase = phase_reg;

  // ************************************************************
  // Main output substitution
  // ************************************************************
  always_comb begin
    main_next = i_main_data;
    case (mode_reg)
      PASS_THROUGH_MODE: begin
        main_next = i_main_data;
      end
      BRIGHT_LEVEL_MODE: begin
        if (i_main_active && !last_line) begin
          main_next = `PLBM_LEVEL_FULL;
        end
      end
      DARK_LEVEL_MODE: begin
        if (i_main_active && !last_line) begin
          main_next = `PLBM_LEVEL_ZERO;
        end
      end
      LEVEL_ALTERNATION_MODE: begin
        if (i_main_active && !last_line) begin
          main_next = phase_reg ? `PLBM_LEVEL_ZERO : `PLBM_LEVEL_FULL;
        end
      end
      BOUNCE_MODE: begin
        if (i_main_active) begin
          main_next = phase_reg ? `PLBM_LEVEL_ZERO : `PLBM_LEVEL_FULL;
        end
      end
      default: begin
        main_next = i_main_data;
      end
    endcase
  end

  // Registered outputs
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_main_data <= 10'h000;
    end else begin
      o_main_data <= main_next;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_aux_data <= 10'h000;
    end else begin
      o_aux_data <= i_aux_data;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  a_aux_untouched: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    !$past(i_sys_rst) |-> o_aux_data == $past(i_aux_data))
    else $error("other output altered");

  a_pass_exact: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (mode_reg == PASS_THROUGH_MODE) |=> o_main_data == $past(i_main_data))
    else $error("pass-through changed a sample");

  a_bright_lines: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (mode_reg == BRIGHT_LEVEL_MODE && i_main_active) |=>
    o_main_data == ($past(last_line) ? $past(i_main_data)
                                     : `PLBM_LEVEL_FULL))
    else $error("bright line substitution wrong");

  a_dark_lines: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (mode_reg == DARK_LEVEL_MODE && i_main_active && !last_line) |=>
    o_main_data == `PLBM_LEVEL_ZERO)
    else $error("dark line substitution wrong");

  a_group_bound: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_line_start && !i_frame_start && last_line) |=> line_cnt_reg == 3'h0)
    else $error("line group did not wrap");

  a_bounce_level: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (mode_reg == BOUNCE_MODE && i_main_active) |=>
    o_main_data == ($past(phase_reg) ? `PLBM_LEVEL_ZERO
                                     : `PLBM_LEVEL_FULL))
    else $error("bounce level wrong");

  a_alt_swap: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_frame_start && alternating && swap_pend_reg) |=>
    phase_reg != $past(phase_reg))
    else $error("phase did not swap at frame");

  a_timer_idle: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    !alternating |=> !expired)
    else $error("timer ran outside alternating modes");

  a_recall_dflt: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    i_default_recall |=> (pend_mode_reg == PASS_THROUGH_MODE &&
                          pend_period_reg == `PLBM_PERIOD_DFLT))
    else $error("default recall not applied");

  a_frame_apply: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    !i_frame_start |=> ($stable(mode_reg) && $stable(phase_reg)))
    else $error("change outside frame boundary");

endmodule : plbm_modifier

// ---- dv/plbm_video_sink.sv ----
// Purpose : Output stage model fed by the picture level modifier
// Assumes : One sample per clock, registered by the modifier
// Notes   : Tallies full and zero flat field samples it receives
`timescale 1ns/1ns
`include "plbm_map.svh"

module plbm_video_sink
  import plbm_pkg::*;
(
  input  wire logic         i_ref_clk,   // Sample clock
  input  wire logic         i_sys_rst,   // Async reset, active high
  input  wire plbm_sample_t i_sample,    // Sample from the modifier
  output int                o_full_cnt,  // Full level samples seen
  output int                o_zero_cnt   // Zero level samples seen
);
  // Count flat field levels as the stage latches each sample
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_full_cnt <= 0;
      o_zero_cnt <= 0;
    end else begin
      if (i_sample === `PLBM_LEVEL_FULL) o_full_cnt <= o_full_cnt + 1;
      if (i_sample === `PLBM_LEVEL_ZERO) o_zero_cnt <= o_zero_cnt + 1;
    end
  end
endmodule : plbm_video_sink

// ---- dv/tb_top.sv ----
// Purpose : Self-checking bench for the picture level modifier
// Assumes : Frames of 6 lines of 8 samples, period step of 20 cycles
// Notes   : Phase and period timer are modelled here, toggle rate bounded
`timescale 1ns/1ns
`include "plbm_map.svh"

module tb_top
  import plbm_pkg::*;
;
  // ****************************************
  // Signals and bench state
  // ****************************************
  logic         i_ref_clk = 0;     // 50 MHz clock
  logic         i_sys_rst = 1;     // Reset, active high
  plbm_sample_t d = 0, aux = 0, om, oa, d_s = 0;
  logic         act = 0, ls = 0, fs = 0, pal = 0, ld = 0, rc = 0;
  logic [2:0]   mc = 0, mode_f = 0, mode_p = 0, m_s = 0, m_old = 0;
  logic [1:0]   pc = 0;            // Requested period code
  logic         ph, ph_prev = 0, a_s = 0, q_ld = 0, q_rc = 0, pal_req = 0;
  int           fc, zc, efull = 0, ezero = 0, tog = 0, cyc = 0;
  int           seed = 19942, miscompares = 0, cmp_count = 0;
  int           pos = 47, idx = 0, k_s = 0, n_s = 5;
  localparam int STEP = 20;        // Bench half-second step in cycles
  int           tc = 0, ts = 0;    // Model step cycle and step counts
  logic         mph = 0, msw = 0, mx = 0; // Model phase, swap, expiry
  logic [1:0]   per_f = `PLBM_PERIOD_DFLT; // Model period in force
  logic [1:0]   per_p = `PLBM_PERIOD_DFLT; // Model pending period
  logic [1:0]   p_s = `PLBM_PERIOD_DFLT;   // Period of the driven cycle

  always #10 i_ref_clk = ~i_ref_clk;

  plbm_modifier #(.STEP_CYC(STEP)) plbm_modifier_i (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_main_data(d),
    .i_main_active(act), .i_line_start(ls), .i_frame_start(fs),
    .i_aux_data(aux), .i_fmt_pal(pal), .i_mode_code(mc),
    .i_period_code(pc), .i_settings_load(ld), .i_default_recall(rc),
    .o_main_data(om), .o_aux_data(oa), .o_dark_phase(ph));

  plbm_video_sink plbm_video_sink_i (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_sample(om),
    .o_full_cnt(fc), .o_zero_cnt(zc));

  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic stop_test();
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Expected main sample from mode, line slot and phase
  function automatic plbm_sample_t expect_main(
    logic [2:0] m, logic a, int k, int n, logic p, plbm_sample_t x);
    logic sub;
    plbm_sample_t lv;
    sub = a && (k != n - 1);
    lv = p ? `PLBM_LEVEL_ZERO : `PLBM_LEVEL_FULL;
    case (m)
      3'h1: return sub ? `PLBM_LEVEL_FULL : x;
      3'h2: return sub ? `PLBM_LEVEL_ZERO : x;
      3'h3: return sub ? lv : x;
      3'h4: return a ? lv : x;
      default: return x;
    endcase
  endfunction : expect_main

  // One clock: check last sample, then drive the next one
  task automatic step();
    plbm_sample_t e;
    logic alt, se, nx;
    @(posedge i_ref_clk);
    #1;
    e = expect_main(m_s, a_s, k_s, n_s, mph, d_s);
    if (m_s == 3'h4) chk(om, e);
    else if (m_s == 3'h3) chk(om, e);
    else if (m_s == 3'h2) chk(om, e);
    else if (m_s == 3'h1) chk(om, e);
    else chk(om, e);
    chk(oa, aux);
    // Advance the phase model over the edge just taken
    alt = (m_s == 3'h3) || (m_s == 3'h4);
    se = (tc == STEP - 1);
    nx = alt && se && (ts >= p_s);
    if (fs) begin
      if (!alt) mph = 1'b0;
      else if (msw) mph = ~mph;
    end
    if (mx) msw = 1'b1;
    else if (fs || !alt) msw = 1'b0;
    if (!alt) ts = 0;
    else if (se) ts = (ts >= p_s) ? 0 : ts + 1;
    if (!alt || se) tc = 0;
    else tc++;
    mx = nx;
    chk(ph, mph);
    if (ph !== ph_prev) begin
      tog++;
      chk(fs, 1'b1);
    end
    if (m_s == 3'h0 && m_old == 3'h0) chk(ph, 1'b0);
    if (e === `PLBM_LEVEL_FULL) efull++;
    if (e === `PLBM_LEVEL_ZERO) ezero++;
    ph_prev = ph;
    pos = (pos + 1) % 48;
    fs = (pos == 0);
    ls = (pos % 8 == 0);
    act = (pos % 8 >= 2);
    d = $random(seed);
    aux = $random(seed);
    if (fs) begin
      pal = pal_req;
      idx = 0;
    end else if (ls) idx = (idx + 1) % (pal ? 4 : 5);
    m_s = mode_f;
    p_s = per_f;
    a_s = act;
    k_s = idx;
    n_s = pal ? 4 : 5;
    d_s = d;
    if (fs) begin
      m_old = mode_f;
      mode_f = mode_p;
      per_f = per_p;
    end
    ld = 0;
    rc = 0;
    if (!fs && (q_ld || q_rc)) begin
      ld = q_ld;
      rc = q_rc;
      mode_p = q_rc ? 3'h0 : ((mc > 3'h4) ? 3'h0 : mc);
      per_p = q_rc ? `PLBM_PERIOD_DFLT : pc;
      q_ld = 0;
      q_rc = 0;
    end
  endtask : step

  // Cut a hang short
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      stop_test();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    int lo;
    int hi;
    repeat (6) @(posedge i_ref_clk);
    #1 i_sys_rst = 0;
    // Every mode code, random period and format, random dwell
    for (int i = 0; i < 24; i++) begin
      mc = i[2:0];
      pc = $random(seed);
      pal_req = $random(seed);
      q_ld = 1;
      repeat (48 + ($random(seed) & 127)) step();
    end
    // Recall and load together: recall must win
    mc = 3'h4;
    q_ld = 1;
    q_rc = 1;
    repeat (120) step();
    // Bounce toggle rate for each period code
    for (int i = 0; i < 4; i++) begin
      mc = 3'h4;
      pc = i[1:0];
      q_ld = 1;
      repeat (96) step();
      tog = 0;
      repeat (960) step();
      lo = 960 / ((i + 1) * 20 + 48) - 1;
      hi = 960 / ((i + 1) * 20) + 2;
      if (hi > 20) hi = 20;
      chk(tog >= lo && tog <= hi, 1'b1);
    end
    // Let the output stage latch the last checked sample
    @(posedge i_ref_clk);
    #1;
    chk(fc, efull);
    chk(zc, ezero);
    stop_test();
  end
endmodule : tb_top
